// file: bench/fdh_nvm_model.sv
`timescale 1ns/1ps
module fdh_nvm_model
  import fdh_pkg::*;
#(
  parameter logic [15:0] SPEED_FLOOR_DEF = 16'h012c,
  parameter logic [15:0] SPEED_CEIL_DEF = 16'h07d0,
  parameter logic [15:0] CURRENT_DEF = 16'h1964,
  parameter logic [15:0] POWER_DEF = 16'h0546
) (
  // clock
  input wire logic clk_sys_i,
  // store port
  input wire logic [5:0] nvm_addr_i,
  input wire logic nvm_we_i,
  input wire logic [15:0] nvm_wdata_i,
  output logic [15:0] nvm_rdata_o
);
  logic [15:0] mem [0:NVM_WORDS-1];

  // factory image, loaded once; reset never clears it, so saves outlive a power cycle
  // factory speed limits, current, skip, power, address and line setup
  initial begin
    for (int i = 0; i < NVM_WORDS; i++) begin
      mem[i] = 16'h0000;
    end
    mem[1] = SPEED_FLOOR_DEF;
    mem[2] = SPEED_CEIL_DEF;
    mem[7] = CURRENT_DEF;
    mem[32] = SKIP_MAX;
    mem[33] = SKIP_MAX;
    mem[36] = POWER_DEF;
    mem[45] = 16'h0001;
    mem[47] = 16'h0060;
  end

  // synchronous read, one cycle late; a save lands on the strobe edge
  // only strobed words are kept
  always @(posedge clk_sys_i) begin
    if (nvm_we_i) begin
      mem[nvm_addr_i] <= nvm_wdata_i;
    end
    nvm_rdata_o <= mem[nvm_addr_i];
  end
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fdh_pkg::*;
  logic clk_sys_i, rstn_i, req_valid_i, rsp_valid_o, nvm_we_o, fan_running_i;
  logic ready_o, fault_clear_o, comm_loss_stop_o, low_thr_en_o;
  fdh_req_type req_i;
  fdh_rsp_type rsp_o, seen_r;
  logic [15:0] inreg_data_i, nvm_wdata_o, nvm_rdata_i, mode_o, speed_cmd_o, rs485_rate_o, seen_wd;
  logic [5:0] nvm_addr_o, seen_wa;
  logic [1:0] rs485_parity_o;
  logic [7:0] rs485_addr_o, own_sl;
  logic seen_v, seen_we, seen_clr, port_uart;
  int miscompares, num_checks, n;

  // short tick keeps the link-loss wait to tens of cycles
  fdh_regbank #(.TICK_CYCLES(10)) fdh_regbank_inst (.clk_sys_i, .rstn_i, .req_valid_i, .req_i,
    .inreg_data_i, .rsp_o, .rsp_valid_o, .nvm_addr_o, .nvm_we_o, .nvm_wdata_o, .nvm_rdata_i,
    .fan_running_i, .ready_o, .fault_clear_o, .comm_loss_stop_o, .mode_o, .speed_cmd_o,
    .low_thr_en_o, .rs485_rate_o, .rs485_parity_o, .rs485_addr_o);
  fdh_nvm_model fdh_nvm_model_inst (.clk_sys_i(clk_sys_i), .nvm_addr_i(nvm_addr_o),
    .nvm_we_i(nvm_we_o), .nvm_wdata_i(nvm_wdata_o), .nvm_rdata_o(nvm_rdata_i));

  // 40 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // an exception is judged by its code, a normal answer by its data
  task automatic rsp_is(input string nm, input logic e, input logic [15:0] x);
    chk({nm, " answered"}, 16'h0001, {15'h0, seen_v});
    chk({nm, " exc"}, {15'h0, e}, {15'h0, seen_r.exc});
    chk(nm, x, e ? {8'h00, seen_r.code} : seen_r.data);
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  // one request cycle, answer captured in the next; an idle cycle keeps strobes apart
  task automatic send(input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] ad, input logic [15:0] dt);
    req_i = '{uart: port_uart, slave: sl, func: fn, addr: ad, data: dt};
    req_valid_i = 1'b1;
    step(1);
    req_valid_i = 1'b0;
    seen_v = rsp_valid_o;
    seen_r = rsp_o;
    seen_we = nvm_we_o;
    seen_clr = fault_clear_o;
    seen_wa = nvm_addr_o;
    seen_wd = nvm_wdata_o;
    step(1);
  endtask

  task automatic wr(input logic [15:0] ad, input logic [15:0] dt);
    send(own_sl, FN_WR, ad, dt);
  endtask

  task automatic rd(input logic [15:0] ad);
    send(own_sl, FN_RD_HOLD, ad, 16'h0000);
  endtask

  // power cycle: store image reloads the working copy
  task automatic do_reset;
    rstn_i = 1'b0;
    step(16);
    rstn_i = 1'b1;
    n = 0;
    while (ready_o !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic t_boot;
    chk("rate", 16'h0060, rs485_rate_o);
    chk("parity", 16'h0000, {14'h0, rs485_parity_o});
    chk("addr out", 16'h0001, {8'h00, rs485_addr_o});
    rd(R_ADDR);
    rsp_is("addr", 1'b0, 16'h0001);
    rd(R_CLEAR);
    rsp_is("clear rd", 1'b0, 16'h0000);
  endtask

  task automatic t_persist;
    fan_running_i = 1'b1;
    wr(R_MODE, MODE_FIXED);
    rsp_is("mode wr", 1'b0, MODE_FIXED);
    chk("run save", 16'h0000, {15'h0, seen_we});
    step(1);
    chk("mode", MODE_FIXED, mode_o);
    wr(R_ADDR, 16'h0005);
    fan_running_i = 1'b0;
    wr(R_MODE, MODE_FIXED);
    chk("stop save", 16'h0001, {15'h0, seen_we});
    chk("save addr", R_MODE, {10'h000, seen_wa});
    chk("save data", MODE_FIXED, seen_wd);
    do_reset();
    rd(R_ADDR);
    rsp_is("addr revert", 1'b0, 16'h0001);
    rd(R_MODE);
    rsp_is("mode kept", 1'b0, MODE_FIXED);
    wr(R_ADDR, 16'h0005);
    step(2);
    chk("addr late", 16'h0001, {8'h00, rs485_addr_o});
    do_reset();
    chk("addr new", 16'h0005, {8'h00, rs485_addr_o});
    rd(R_ADDR);
    chk("old addr", 16'h0000, {15'h0, seen_v});
    own_sl = 8'h05;
    rd(R_ADDR);
    rsp_is("new addr", 1'b0, 16'h0005);
    port_uart = 1'b1;
    own_sl = UART_ADDR;
    rd(R_ADDR);
    rsp_is("uart addr", 1'b0, 16'h0005);
  endtask

  task automatic t_line;
    wr(R_RATE, 16'h00c0);
    step(1);
    chk("rate new", 16'h00c0, rs485_rate_o);
    wr(R_RATE, 16'h0064);
    rsp_is("rate bad", 1'b1, {8'h00, EX_VALUE});
    rd(R_RATE);
    rsp_is("rate kept", 1'b0, 16'h00c0);
    for (int p = 2; p >= 0; p--) begin
      wr(R_PAR, p[15:0]);
      rsp_is("parity code", 1'b0, p[15:0]);
    end
    wr(R_PAR, 16'h0002);
    step(2);
    chk("parity late", 16'h0000, {14'h0, rs485_parity_o});
    wr(R_PAR, 16'h0003);
    rsp_is("parity bad", 1'b1, {8'h00, EX_VALUE});
  endtask

  task automatic t_speed;
    wr(R_FLOOR, 16'h012b);
    rsp_is("floor low", 1'b1, {8'h00, EX_VALUE});
    wr(R_CEIL, 16'h07d1);
    rsp_is("ceil high", 1'b1, {8'h00, EX_VALUE});
    wr(R_CEIL, 16'h0300);
    rsp_is("ceil ok", 1'b0, 16'h0300);
    wr(R_FLOOR, 16'h0301);
    rsp_is("floor over", 1'b1, {8'h00, EX_VALUE});
    wr(R_CEIL, 16'h012b);
    rsp_is("ceil under", 1'b1, {8'h00, EX_VALUE});
    wr(R_FIXED, 16'h0301);
    rsp_is("fixed bad", 1'b1, {8'h00, EX_VALUE});
    wr(R_FIXED, 16'h0300);
    wr(R_TEMP, 16'h1234);
    step(1);
    chk("fixed cmd", 16'h0300, speed_cmd_o);
    rd(R_TEMP);
    rsp_is("temp rd", 1'b1, {8'h00, EX_ADDR});
    wr(R_MODE, 16'h0000);
    step(1);
    chk("temp cmd", 16'h1234, speed_cmd_o);
  endtask

  task automatic t_misc;
    wr(R_CUR, 16'h0000);
    rsp_is("cur zero", 1'b1, {8'h00, EX_VALUE});
    wr(R_CUR, CUR_MIN);
    rsp_is("cur min", 1'b0, CUR_MIN);
    wr(R_CLEAR, CLEAR_GO);
    chk("clear pulse", 16'h0001, {15'h0, seen_clr});
    chk("clear end", 16'h0000, {15'h0, fault_clear_o});
    rd(R_CLEAR);
    rsp_is("clear back", 1'b0, 16'h0000);
    inreg_data_i = 16'hbeef;
    send(own_sl, FN_RD_IN, 16'h0003, 16'h0000);
    rsp_is("input rd", 1'b0, 16'hbeef);
    send(own_sl, 8'h10, R_MODE, 16'h0000);
    rsp_is("bad func", 1'b1, {8'h00, EX_FUNC});
    rd(16'h0040);
    rsp_is("past end", 1'b1, {8'h00, EX_ADDR});
    wr(16'h0003, 16'h0000);
    rsp_is("locked reg", 1'b1, {8'h00, EX_ADDR});
    wr(R_DOF, DOF_WINDOW);
    step(1);
    chk("low thr on", 16'h0001, {15'h0, low_thr_en_o});
    wr(R_DOF, 16'h0002);
    step(1);
    chk("low thr off", 16'h0000, {15'h0, low_thr_en_o});
  endtask

  // two seconds at ten cycles per tick
  task automatic t_timeout;
    wr(R_TMO, 16'h0002);
    n = 0;
    while (comm_loss_stop_o !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk("loss time", 16'h0001, {15'h0, n >= 17 && n <= 23});
    send(BCAST, FN_WR, R_TMO, 16'h0002);
    chk("bcast quiet", 16'h0000, {15'h0, seen_v});
    chk("bcast kick", 16'h0000, {15'h0, comm_loss_stop_o});
    wr(R_TMO, 16'h0000);
    step(40);
    chk("loss off", 16'h0000, {15'h0, comm_loss_stop_o});
  endtask

  initial begin
    miscompares = 0;
    num_checks = 0;
    rstn_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    inreg_data_i = 16'h0000;
    fan_running_i = 1'b0;
    port_uart = 1'b0;
    own_sl = ADDR_DEF;
    #1;
    do_reset();
    t_boot();
    t_persist();
    t_line();
    t_speed();
    t_misc();
    t_timeout();
    tally_and_finish();
  end
endmodule

// file: src/fdh_pkg.sv
// Behaviour
// - writes while running take effect at once in the working copy, not saved
// - writes are saved to nonvolatile memory only while the fan is stopped
// - stop fan after timeout seconds without traffic; zero disables the timeout
// - own slave address programmable 1 to 247, factory default 1
// - slave address 0 is broadcast
// - RS-485 defaults are 9600 baud, parity code 0, address 1
// - UART port always 57600 baud, parity code 0, address 1
// - baud change is immediate; parity and address apply after power cycle
// - baud and parity registers configure only the RS-485 port
// - temporary setpoint is write-only and carries the mode's reference
// - temporary setpoint is volatile, held while the controller stays powered
// - 64 holding registers kept in nonvolatile memory, few user writable
// - holding register R_MODE selects the operating mode
// - writing 1 to reset register clears faults, restarts, reads back 0
// - speed floor accepts factory default up to current speed ceiling
// - speed ceiling accepts current speed floor up to factory default
// - low speed threshold only acts while output function holds 3
// - fixed speed used only in mode 2, range floor to ceiling, default 0
// - out-of-range write leaves stored value unchanged, no clamping
// - functions 03, 04 and 06 are supported
// - parity code 0 none two stops, 1 odd, 2 even, one stop
package fdh_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYC = CLK_HZ * TICK_S;
  localparam int NVM_WORDS = 64;
  localparam int UART_BAUD = 57600;
  localparam int RS485_BAUD = 9600;
  // holding register offsets
  localparam logic [15:0] R_CLEAR = 16'h0000;
  localparam logic [15:0] R_FLOOR = 16'h0001;
  localparam logic [15:0] R_CEIL = 16'h0002;
  localparam logic [15:0] R_CUR = 16'h0007;
  localparam logic [15:0] R_LOWTH = 16'h0010;
  localparam logic [15:0] R_FIXED = 16'h0015;
  localparam logic [15:0] R_POL = 16'h001f;
  localparam logic [15:0] R_SKIPLO = 16'h0020;
  localparam logic [15:0] R_SKIPHI = 16'h0021;
  localparam logic [15:0] R_MODE = 16'h0022;
  localparam logic [15:0] R_COAST = 16'h0023;
  localparam logic [15:0] R_POWER = 16'h0024;
  localparam logic [15:0] R_ADDR = 16'h002d;
  localparam logic [15:0] R_DOF = 16'h002e;
  localparam logic [15:0] R_RATE = 16'h002f;
  localparam logic [15:0] R_PAR = 16'h0030;
  localparam logic [15:0] R_LREF = 16'h0032;
  localparam logic [15:0] R_PGAIN = 16'h0033;
  localparam logic [15:0] R_IGAIN = 16'h0034;
  localparam logic [15:0] R_DGAIN = 16'h0035;
  localparam logic [15:0] R_LTIME = 16'h0036;
  localparam logic [15:0] R_HITH = 16'h0037;
  localparam logic [15:0] R_TMO = 16'h0038;
  localparam logic [15:0] R_TEMP = 16'h0042;
  // function and exception codes
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_IN = 8'h04;
  localparam logic [7:0] FN_WR = 8'h06;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_VALUE = 8'h03;
  // addressing and value limits
  localparam logic [7:0] BCAST = 8'h00;
  localparam logic [7:0] UART_ADDR = 8'h01;
  localparam logic [7:0] ADDR_DEF = 8'h01;
  localparam logic [15:0] ADDR_MIN = 16'h0001;
  localparam logic [15:0] ADDR_MAX = 16'h00f7;
  localparam logic [15:0] RATE_LO = 16'h0060;
  localparam logic [15:0] RATE_HI = 16'h00c0;
  localparam logic [1:0] PAR_DEF = 2'h0;
  localparam logic [15:0] PAR_MAX = 16'h0002;
  localparam logic [15:0] MODE_MAX = 16'h000c;
  localparam logic [15:0] MODE_FIXED = 16'h0002;
  localparam logic [15:0] DOF_MAX = 16'h0003;
  localparam logic [15:0] DOF_WINDOW = 16'h0003;
  localparam logic [15:0] POL_MAX = 16'h0001;
  localparam logic [15:0] LREF_MAX = 16'h0064;
  localparam logic [15:0] WORD_MAX = 16'h7fff;
  localparam logic [15:0] SKIP_MAX = 16'h4e20;
  localparam logic [15:0] POWER_MIN = 16'h000a;
  localparam logic [15:0] CUR_MIN = 16'h0001;
  localparam logic [15:0] CLEAR_GO = 16'h0001;

  typedef struct packed {
    logic uart;
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } fdh_req_type;

  typedef struct packed {
    logic exc;
    logic [7:0] code;
    logic [15:0] data;
  } fdh_rsp_type;
endpackage

// file: src/fdh_regbank.sv
`timescale 1ns/1ps
module fdh_regbank
  import fdh_pkg::*;
#(
  parameter logic [15:0] SPEED_FLOOR_DEF = 16'h012c,
  parameter logic [15:0] SPEED_CEIL_DEF = 16'h07d0,
  parameter logic [15:0] CURRENT_DEF = 16'h1964,
  parameter logic [15:0] POWER_DEF = 16'h0546,
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // decoded frames from the link layer
  input wire logic req_valid_i,
  input wire fdh_req_type req_i,
  input wire logic [15:0] inreg_data_i,
  output fdh_rsp_type rsp_o,
  output logic rsp_valid_o,
  // nonvolatile store
  output logic [5:0] nvm_addr_o,
  output logic nvm_we_o,
  output logic [15:0] nvm_wdata_o,
  input wire logic [15:0] nvm_rdata_i,
  // motor side
  input wire logic fan_running_i,
  output logic ready_o,
  output logic fault_clear_o,
  output logic comm_loss_stop_o,
  output logic [15:0] mode_o,
  output logic [15:0] speed_cmd_o,
  output logic low_thr_en_o,
  // rs-485 line setup
  output logic [15:0] rs485_rate_o,
  output logic [1:0] rs485_parity_o,
  output logic [7:0] rs485_addr_o
);

  typedef enum logic {ST_BOOT = 1'b0, ST_RUN = 1'b1} fdh_state_type;

  fdh_state_type state;
  logic [15:0] regs [0:NVM_WORDS-1];
  logic [6:0] boot_idx;
  logic boot_pend;
  logic load_pend;
  logic [5:0] load_addr;
  logic [15:0] temp_set;
  logic [31:0] tick_cnt;
  logic [15:0] sec_cnt;
  fdh_rsp_type next_rsp;
  logic hit, bcast, in_map, user_reg, range_ok, wr_ok, keep;
  logic [5:0] idx;
  logic [7:0] my_addr;

  // user-writable holding registers
  function automatic logic is_user(input logic [15:0] a);
    case (a)
      R_CLEAR, R_FLOOR, R_CEIL, R_CUR, R_LOWTH, R_FIXED, R_POL,
      R_SKIPLO, R_SKIPHI, R_MODE, R_COAST, R_POWER, R_ADDR, R_DOF,
      R_RATE, R_PAR, R_LREF, R_PGAIN, R_IGAIN, R_DGAIN, R_LTIME,
      R_HITH, R_TMO, R_TEMP: is_user = 1'b1;
      default: is_user = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] rd(input logic [15:0] a);
    rd = regs[a[5:0]];
  endfunction

  // frame decode
  // broadcast match
  assign bcast = (req_i.slave == BCAST);
  // uart port answers on its fixed address
  assign my_addr = req_i.uart ? UART_ADDR : rs485_addr_o;
  // requests wait for ready_o, so the latched address is already in place
  assign hit = req_valid_i && ready_o && (bcast || req_i.slave == my_addr);
  assign idx = req_i.addr[5:0];
  assign in_map = (req_i.addr < 16'(NVM_WORDS));
  assign user_reg = is_user(req_i.addr);
  assign wr_ok = hit && req_i.func == FN_WR && user_reg && range_ok;
  // reset register and temporary setpoint live outside the store
  assign keep = req_i.addr != R_CLEAR && req_i.addr != R_TEMP;

  // allowed value windows per register
  always_comb begin
    unique case (req_i.addr)
      R_CLEAR: range_ok = req_i.data <= CLEAR_GO;
      R_FLOOR: range_ok = req_i.data >= SPEED_FLOOR_DEF && req_i.data <= rd(R_CEIL);
      R_CEIL: range_ok = req_i.data >= rd(R_FLOOR) && req_i.data <= SPEED_CEIL_DEF;
      R_CUR: range_ok = req_i.data >= CUR_MIN && req_i.data <= CURRENT_DEF;
      // fixed speed within floor and ceiling
      R_FIXED: range_ok = req_i.data >= rd(R_FLOOR) && req_i.data <= rd(R_CEIL);
      R_POL: range_ok = req_i.data <= POL_MAX;
      R_SKIPLO: range_ok = req_i.data <= rd(R_SKIPHI);
      R_SKIPHI: range_ok = req_i.data >= rd(R_SKIPLO) && req_i.data <= SKIP_MAX;
      R_MODE: range_ok = req_i.data <= MODE_MAX;
      R_POWER: range_ok = req_i.data >= POWER_MIN && req_i.data <= POWER_DEF;
      R_ADDR: range_ok = req_i.data >= ADDR_MIN && req_i.data <= ADDR_MAX;
      R_DOF: range_ok = req_i.data <= DOF_MAX;
      R_RATE: range_ok = req_i.data == RATE_LO || req_i.data == RATE_HI;
      // only codes 0 to 2 exist
      R_PAR: range_ok = req_i.data <= PAR_MAX;
      R_LREF: range_ok = req_i.data <= LREF_MAX;
      default: range_ok = req_i.data <= WORD_MAX;
    endcase
  end

  // answer builder
  // read holding, read input, write single
  always_comb begin
    next_rsp = '0;
    unique case (req_i.func)
      FN_RD_HOLD: begin
        if (req_i.addr == R_TEMP || !in_map) begin
          next_rsp.exc = 1'b1;
          next_rsp.code = EX_ADDR;
        end else begin
          next_rsp.data = (req_i.addr == R_CLEAR) ? 16'h0000 : regs[idx];
        end
      end
      FN_RD_IN: next_rsp.data = inreg_data_i;
      FN_WR: begin
        next_rsp.data = req_i.data;
        if (!user_reg) begin
          next_rsp.exc = 1'b1;
          next_rsp.code = EX_ADDR;
        end else if (!range_ok) begin
          next_rsp.exc = 1'b1;
          next_rsp.code = EX_VALUE;
        end
      end
      default: begin
        next_rsp.exc = 1'b1;
        next_rsp.code = EX_FUNC;
      end
    endcase
  end

  // answer port; broadcasts stay silent
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o <= '0;
    end else begin
      rsp_valid_o <= hit && !bcast;
      if (hit) begin
        rsp_o <= next_rsp;
      end
    end
  end

  // boot sequencer pulls the stored copy back in
  // power loss reverts to the saved values
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_BOOT;
      boot_idx <= 7'h00;
      boot_pend <= 1'b0;
      load_pend <= 1'b0;
      load_addr <= 6'h00;
    end else if (state == ST_BOOT) begin
      boot_pend <= boot_idx < 7'(NVM_WORDS);
      if (boot_idx < 7'(NVM_WORDS)) begin
        boot_idx <= boot_idx + 7'h01;
      end
      // store read is synchronous: data pairs with the previous address
      load_pend <= boot_pend;
      load_addr <= nvm_addr_o;
      if (load_pend && load_addr == 6'(NVM_WORDS - 1)) begin
        state <= ST_RUN;
      end
    end else begin
      boot_pend <= 1'b0;
      load_pend <= 1'b0;
    end
  end

  // working copy; a memory, so no reset
  // all 64 words are loaded from the store at boot
  always_ff @(posedge clk_sys_i) begin
    // boot capture trails the store address by one cycle
    if (load_pend) begin
      regs[load_addr] <= nvm_rdata_i;
    end else if (wr_ok && keep && in_map) begin
      regs[idx] <= req_i.data;
    end
  end

  // store port, shared between boot reads and saves
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nvm_addr_o <= 6'h00;
      nvm_we_o <= 1'b0;
      nvm_wdata_o <= 16'h0000;
    end else begin
      nvm_we_o <= 1'b0;
      if (state == ST_BOOT) begin
        nvm_addr_o <= boot_idx[5:0];
      end else if (wr_ok && keep && in_map && !fan_running_i) begin
        nvm_we_o <= 1'b1;
        nvm_addr_o <= idx;
        nvm_wdata_o <= req_i.data;
      end
    end
  end

  // line setup; parity and address frozen after boot
  // power-up defaults
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rs485_rate_o <= RATE_LO;
      rs485_parity_o <= PAR_DEF;
      rs485_addr_o <= ADDR_DEF;
      ready_o <= 1'b0;
    end else begin
      ready_o <= state == ST_RUN;
      // rate follows the register at once
      // only the rs-485 port sees these
      if (state == ST_RUN) begin
        rs485_rate_o <= rd(R_RATE);
      end
      // parity and address latched once per power-up
      if (state == ST_RUN && !ready_o) begin
        rs485_parity_o <= regs[R_PAR[5:0]][1:0];
        rs485_addr_o <= regs[R_ADDR[5:0]][7:0];
      end
    end
  end

  // temporary setpoint and restart pulse
  // volatile, held until power is gone
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      temp_set <= 16'h0000;
      fault_clear_o <= 1'b0;
    end else begin
      if (wr_ok && req_i.addr == R_TEMP) begin
        temp_set <= req_i.data;
      end
      fault_clear_o <= wr_ok && req_i.addr == R_CLEAR && req_i.data == CLEAR_GO;
    end
  end

  // mode-dependent outputs
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_o <= 16'h0000;
      speed_cmd_o <= 16'h0000;
      low_thr_en_o <= 1'b0;
    end else if (state == ST_RUN) begin
      mode_o <= rd(R_MODE);
      // fixed speed only in mode 2
      // otherwise the temporary setpoint is the reference
      speed_cmd_o <= (rd(R_MODE) == MODE_FIXED) ? rd(R_FIXED) : temp_set;
      // low threshold only in window mode
      low_thr_en_o <= rd(R_DOF) == DOF_WINDOW;
    end
  end

  // link-loss watchdog; one-second enable from a divider
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt <= 32'h0000_0000;
      sec_cnt <= 16'h0000;
      comm_loss_stop_o <= 1'b0;
    end else if (hit || state == ST_BOOT || rd(R_TMO) == 16'h0000) begin
      // any frame for us restarts the count
      tick_cnt <= 32'h0000_0000;
      sec_cnt <= 16'h0000;
      comm_loss_stop_o <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0000_0000;
      if (sec_cnt != 16'hffff) begin
        sec_cnt <= sec_cnt + 16'h0001;
      end
      // stop once the seconds run out
      if (sec_cnt + 16'h0001 >= rd(R_TMO)) begin
        comm_loss_stop_o <= 1'b1;
      end
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // checks
  sequence s_wr(logic [15:0] a);
    hit && req_i.func == FN_WR && req_i.addr == a;
  endsequence

  sequence s_pulse;
    fault_clear_o ##1 !fault_clear_o;
  endsequence

  a_answer_next: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    hit && !bcast |=> rsp_valid_o)
    else $error("addressed frame got no answer");

  a_bcast_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    hit && bcast |=> !rsp_valid_o)
    else $error("broadcast was answered");

  a_temp_noread: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    hit && !bcast && req_i.func == FN_RD_HOLD && req_i.addr == R_TEMP |=> rsp_o.exc && rsp_o.code == EX_ADDR)
    else $error("temporary setpoint read returned data");

  a_clear_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_wr(R_CLEAR) ##0 req_i.data == CLEAR_GO |=> s_pulse)
    else $error("restart pulse missing or too long");

  a_run_nosave: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    hit && fan_running_i && state == ST_RUN |=> !nvm_we_o)
    else $error("running write reached the store");

  a_stop_save: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_ok && keep && !fan_running_i |=> nvm_we_o && nvm_wdata_o == $past(req_i.data))
    else $error("stopped write not saved");

  a_range_keep: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    hit && req_i.func == FN_WR && user_reg && !range_ok && keep && in_map
    |=> rsp_o.exc && regs[$past(idx)] == $past(regs[idx]))
    else $error("out-of-range write changed the register");

  a_link_fresh: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    hit |=> !comm_loss_stop_o && sec_cnt == 16'h0000)
    else $error("frame did not restart the watchdog");

  a_par_frozen: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ready_o |=> $stable(rs485_parity_o) && $stable(rs485_addr_o))
    else $error("parity or address changed while powered");

  a_fixed_mode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    state == ST_RUN && regs[R_MODE[5:0]] == MODE_FIXED |=> speed_cmd_o == $past(regs[R_FIXED[5:0]]))
    else $error("fixed speed not driven in mode 2");

  a_mode_copy: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    state == ST_RUN |=> mode_o == $past(regs[R_MODE[5:0]]))
    else $error("mode output does not follow its register");

  a_rate_live: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ready_o |=> rs485_rate_o == $past(regs[R_RATE[5:0]]))
    else $error("line rate did not follow its register");

  a_low_thr_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    state == ST_RUN |=> low_thr_en_o == ($past(regs[R_DOF[5:0]]) == DOF_WINDOW))
    else $error("low threshold enable wrong for output function");

  a_loss_disabled: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    state == ST_RUN && regs[R_TMO[5:0]] == 16'h0000 |=> !comm_loss_stop_o)
    else $error("link-loss stop while timeout disabled");

  a_clear_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    hit && !bcast && req_i.func == FN_RD_HOLD && req_i.addr == R_CLEAR |=> !rsp_o.exc && rsp_o.data == 16'h0000)
    else $error("restart register read back nonzero");

  a_save_addr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_ok && keep && !fan_running_i |=> nvm_addr_o == $past(idx))
    else $error("save went to the wrong store word");

  a_boot_silent: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !ready_o |=> !rsp_valid_o && !nvm_we_o)
    else $error("answer or save before boot load finished");

  a_uart_fixed: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && ready_o && req_i.uart && req_i.slave == UART_ADDR |=> rsp_valid_o)
    else $error("uart port ignored its fixed address");

endmodule
